/* File: verilog/bbs_pkg.sv */
// package: constants, timing and carrier types for the battery-backed sram host controller
// ****************************************************************
// ****************************************************************
package bbs_pkg;

  localparam int unsigned ADDR_W         = 13;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned CLK_PERIOD_PS  = 25000;

  // ****************************************************************
  // timing figures as printed
  // ****************************************************************
  localparam int unsigned ACC_ADDR_NS    = 100;
  localparam int unsigned ACC_SEL_NS     = 100;
  localparam int unsigned ACC_DRV_NS     = 50;
  localparam int unsigned HOLD_ADDR_NS   = 10;
  localparam int unsigned SETUP_STRB_NS  = 50;
  localparam int unsigned DATA_HOLD_NS   = 5;
  localparam int unsigned STRB_LOW_NS    = 80;
  localparam int unsigned CYCLE_NS       = 100;
  localparam int unsigned RECOVERY_MS    = 1;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned RD_ACC_CYC = ns_to_cyc(ACC_ADDR_NS) > ns_to_cyc(ACC_SEL_NS) ?
                                       ns_to_cyc(ACC_ADDR_NS) : ns_to_cyc(ACC_SEL_NS);
  localparam int unsigned DRV_ACC_CYC = ns_to_cyc(ACC_DRV_NS);
  localparam int unsigned WR_LOW_CYC  = ns_to_cyc(STRB_LOW_NS) > ns_to_cyc(SETUP_STRB_NS) ?
                                        ns_to_cyc(STRB_LOW_NS) : ns_to_cyc(SETUP_STRB_NS);
  localparam int unsigned TAIL_CYC    = ns_to_cyc(HOLD_ADDR_NS) > ns_to_cyc(DATA_HOLD_NS) ?
                                        ns_to_cyc(HOLD_ADDR_NS) : ns_to_cyc(DATA_HOLD_NS);
  localparam int unsigned CYCLE_CYC   = ns_to_cyc(CYCLE_NS);
  localparam int unsigned RECOVERY_CYC_DEF = (RECOVERY_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W       = 16;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbs_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              drv_n;
    logic              strb_n;
    logic [ADDR_W-1:0] addr;
  } bbs_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_SETUP,
    ST_WR,
    ST_TAIL,
    ST_GAP
  } bbs_state_t;

endpackage

/* File: verilog/bbs_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module bbs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb begin
    s1_nxt = d_i;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q_o = s2_r;

endmodule
`default_nettype wire

/* File: verilog/bbs_host.sv */
// host-side controller driving the battery-backed 8k x 8 sram pins
`timescale 1ns/100ps
`default_nettype none
module bbs_host
  import bbs_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = RECOVERY_CYC_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire bbs_req_t          req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   rdata_valid_o,
  output logic                   wr_done_o,
  input  wire logic              supply_ok_i,
  output logic                   mem_ready_o,
  output bbs_pins_t              pins_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_n_o,
  input  wire logic [DATA_W-1:0] dq_i
);

  // ****************************************************************
  // pin input synchronisers
  // ****************************************************************
  logic [DATA_W-1:0] dq_s;
  logic              sup_s;

  bbs_sync #(.W(DATA_W + 1)) u_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({supply_ok_i, dq_i}),
    .q_o   ({sup_s, dq_s})
  );

  // ****************************************************************
  // power-up recovery counter
  // ****************************************************************
  logic [31:0] rec_r;
  logic [31:0] rec_nxt;
  logic        pwr_ok_r;
  logic        pwr_ok_nxt;

  always_comb begin
    rec_nxt    = rec_r;
    pwr_ok_nxt = pwr_ok_r;
    if (!sup_s) begin
      rec_nxt    = '0;
      pwr_ok_nxt = 1'b0;
    end else if (!pwr_ok_r) begin
      if (rec_r >= 32'(RECOVERY_CYC)) begin
        pwr_ok_nxt = 1'b1;
      end else begin
        rec_nxt = rec_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rec_r    <= '0;
      pwr_ok_r <= 1'b0;
    end else begin
      rec_r    <= rec_nxt;
      pwr_ok_r <= pwr_ok_nxt;
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  bbs_state_t        st_r;
  bbs_state_t        st_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [CNT_W-1:0]  cyc_r;
  logic [CNT_W-1:0]  cyc_nxt;
  bbs_pins_t         pins_r;
  bbs_pins_t         pins_nxt;
  logic [DATA_W-1:0] dq_r;
  logic [DATA_W-1:0] dq_nxt;
  logic              oe_n_r;
  logic              oe_n_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rv_r;
  logic              rv_nxt;
  logic              wd_r;
  logic              wd_nxt;
  logic              rdy_r;
  logic              rdy_nxt;

  localparam logic [CNT_W-1:0] RD_WAIT  = CNT_W'(RD_ACC_CYC + 2);
  localparam logic [CNT_W-1:0] WR_WAIT  = CNT_W'(WR_LOW_CYC);
  localparam logic [CNT_W-1:0] TAIL_W   = CNT_W'(TAIL_CYC);
  localparam logic [CNT_W-1:0] CYC_MIN  = CNT_W'(CYCLE_CYC);
  localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    cyc_nxt   = (cyc_r == '1) ? cyc_r : cyc_r + ONE;
    pins_nxt  = pins_r;
    dq_nxt    = dq_r;
    oe_n_nxt  = oe_n_r;
    rdata_nxt = rdata_r;
    rv_nxt    = 1'b0;
    wd_nxt    = 1'b0;
    rdy_nxt   = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        pins_nxt.sel_n  = 1'b1;
        pins_nxt.drv_n  = 1'b1;
        pins_nxt.strb_n = 1'b1;
        oe_n_nxt        = 1'b1;
        if (pwr_ok_r && sup_s && req_valid_i && rdy_r) begin
          rdy_nxt       = 1'b0;
          pins_nxt.addr = req_i.addr;
          cnt_nxt       = '0;
          cyc_nxt       = '0;
          if (req_i.wr) begin
            dq_nxt   = req_i.wdata;
            st_nxt   = ST_WR_SETUP;
          end else begin
            pins_nxt.sel_n = 1'b0;
            pins_nxt.drv_n = 1'b0;
            st_nxt         = ST_RD;
          end
        end else begin
          rdy_nxt = pwr_ok_r && sup_s;
        end
      end
      ST_RD: begin
        cnt_nxt = cnt_r + ONE;
        if (cnt_r >= RD_WAIT) begin
          rdata_nxt      = dq_s;
          rv_nxt         = 1'b1;
          pins_nxt.sel_n = 1'b1;
          pins_nxt.drv_n = 1'b1;
          cnt_nxt        = '0;
          st_nxt         = ST_GAP;
        end
      end
      ST_WR_SETUP: begin
        pins_nxt.sel_n  = 1'b0;
        pins_nxt.strb_n = 1'b0;
        oe_n_nxt        = 1'b0;
        cnt_nxt         = ONE;
        st_nxt          = ST_WR;
      end
      ST_WR: begin
        cnt_nxt = cnt_r + ONE;
        if (cnt_r >= WR_WAIT) begin
          pins_nxt.strb_n = 1'b1;
          cnt_nxt         = '0;
          st_nxt          = ST_TAIL;
        end
      end
      ST_TAIL: begin
        cnt_nxt = cnt_r + ONE;
        if (cnt_r + ONE >= TAIL_W) begin
          pins_nxt.sel_n = 1'b1;
          oe_n_nxt       = 1'b1;
          wd_nxt         = 1'b1;
          cnt_nxt        = '0;
          st_nxt         = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cyc_r >= CYC_MIN) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (!sup_s && st_r != ST_IDLE) begin
      pins_nxt.sel_n  = 1'b1;
      pins_nxt.drv_n  = 1'b1;
      pins_nxt.strb_n = 1'b1;
      oe_n_nxt        = 1'b1;
      rdy_nxt         = 1'b0;
      st_nxt          = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r    <= ST_IDLE;
      cnt_r   <= '0;
      cyc_r   <= '0;
      pins_r  <= '{sel_n: 1'b1, drv_n: 1'b1, strb_n: 1'b1, addr: '0};
      dq_r    <= '0;
      oe_n_r  <= 1'b1;
      rdata_r <= '0;
      rv_r    <= 1'b0;
      wd_r    <= 1'b0;
      rdy_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      cyc_r   <= cyc_nxt;
      pins_r  <= pins_nxt;
      dq_r    <= dq_nxt;
      oe_n_r  <= oe_n_nxt;
      rdata_r <= rdata_nxt;
      rv_r    <= rv_nxt;
      wd_r    <= wd_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  assign pins_o        = pins_r;
  assign dq_o          = dq_r;
  assign dq_oe_n_o     = oe_n_r;
  assign rdata_o       = rdata_r;
  assign rdata_valid_o = rv_r;
  assign wr_done_o     = wd_r;
  assign req_ready_o   = rdy_r;
  assign mem_ready_o   = pwr_ok_r;

endmodule
`default_nettype wire

/* File: dv/bbs_host_monitor.sv */
// checker of pin timing on the sram host controller
`timescale 1ns/100ps
`default_nettype none
module bbs_host_monitor
  import bbs_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = RECOVERY_CYC_DEF
) (
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              rdata_valid_o,
  input wire logic              supply_ok_i,
  input wire logic              mem_ready_o,
  input wire bbs_pins_t         pins_o,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_ADDR_CHANGE_DESELECTED: assert property (
    $changed(pins_o.addr) |-> $past(pins_o.sel_n)) else $error("address moved while selected");
  AST_READ_CYCLE: assert property (
    $fell(pins_o.sel_n) && pins_o.strb_n |-> !pins_o.sel_n[*7] ##1 (pins_o.sel_n && rdata_valid_o))
    else $error("read cycle length wrong");
  AST_WRITE_SELECT: assert property (
    $fell(pins_o.sel_n) && !pins_o.strb_n |-> $fell(pins_o.strb_n) && pins_o.drv_n ##1
      !pins_o.sel_n[*4] ##1 pins_o.sel_n) else $error("write select width wrong");
  AST_STROBE_WIDTH: assert property (
    $fell(pins_o.strb_n) |-> !pins_o.strb_n[*4] ##1 pins_o.strb_n) else $error("strobe width wrong");
  AST_DATA_SETUP_HOLD: assert property (
    !pins_o.strb_n || $rose(pins_o.strb_n) |-> !dq_oe_n_o && $stable(dq_o))
    else $error("write data not held");
  AST_NO_CONTENTION: assert property (
    !dq_oe_n_o |-> pins_o.drv_n) else $error("output drive low while writing");
  AST_POWER_FAIL_IDLE: assert property (
    !supply_ok_i[*4] |-> pins_o.sel_n && pins_o.strb_n && dq_oe_n_o) else $error("pins active in fail");
  AST_RECOVERY_WAIT: assert property (
    !supply_ok_i ##1 supply_ok_i |-> !mem_ready_o[*8]) else $error("recovery too short");
endmodule
bind bbs_host bbs_host_monitor #(.RECOVERY_CYC(RECOVERY_CYC)) u_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .rdata_valid_o(rdata_valid_o),
  .supply_ok_i(supply_ok_i), .mem_ready_o(mem_ready_o), .pins_o(pins_o), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o));
`default_nettype wire

/* File: dv/bbs_sram_model.sv */
// behavioural model of the battery-backed 8k x 8 sram
`timescale 1ns/100ps
`default_nettype none
module bbs_sram_model
  import bbs_pkg::*;
(
  input  wire bbs_pins_t         pins_i,
  input  wire logic [DATA_W-1:0] host_dq_i,
  input  wire logic              host_oe_n_i,
  input  wire logic              supply_ok_i,
  output logic      [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic              wr_on = 1'b0;
  realtime           t_chg = 0.0;
  wire logic sel = !pins_i.sel_n && supply_ok_i;
  wire logic rd  = sel && pins_i.strb_n && !pins_i.drv_n;
  initial bus_o = '0;
  always @(pins_i.addr or pins_i.sel_n or pins_i.drv_n) t_chg = $realtime;
  always @(pins_i or host_dq_i or host_oe_n_i or sel) begin
    if (wr_on && !(sel && !pins_i.strb_n) && supply_ok_i) mem[wa] = wd;
    wr_on = sel && !pins_i.strb_n;
    if (wr_on) begin
      wa = pins_i.addr;
      if (!host_oe_n_i) wd = host_dq_i;
    end
  end
  always #5 begin
    if (!host_oe_n_i) bus_o = host_dq_i;
    else if (rd && $realtime - t_chg >= ACC_ADDR_NS) bus_o = mem[pins_i.addr];
    else if (!(rd && $realtime - t_chg < 5.0)) bus_o = ~bus_o;
  end
endmodule
`default_nettype wire

/* File: dv/bbs_host_bench.sv */
// testbench for the sram host controller
`timescale 1ns/100ps
`default_nettype none
module bbs_host_bench
  import bbs_pkg::*;
;
  localparam int unsigned REC = 8;
  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              req_valid_i = 1'b0;
  logic              supply_ok_i = 1'b1;
  bbs_req_t          req_i = '0;
  logic              req_ready_o, rdata_valid_o, wr_done_o, mem_ready_o, dq_oe_n_o;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_i;
  bbs_pins_t         pins_o;
  logic [ADDR_W-1:0] al [12];
  logic [DATA_W-1:0] sh [12];
  logic [8:0]        exq [$];
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                seed;
  always #12.5 core_clk_i = ~core_clk_i;
  bbs_host #(.RECOVERY_CYC(REC)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .wr_done_o(wr_done_o), .supply_ok_i(supply_ok_i),
    .mem_ready_o(mem_ready_o), .pins_o(pins_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_i));
  bbs_sram_model mdl (.pins_i(pins_o), .host_dq_i(dq_o), .host_oe_n_i(dq_oe_n_o),
    .supply_ok_i(supply_ok_i), .bus_o(dq_i));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req_i <= '{wr: w, addr: a, wdata: d};
    req_valid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    chk("take", 9'h1, {8'h0, req_ready_o});
    exq.push_back(w ? 9'h100 : {1'b0, d});
  endtask
  task automatic wait_mem();
    int n;
    n = 0;
    while (mem_ready_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("recovery", 9'h1, {8'h0, mem_ready_o === 1'b1 && n >= REC});
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
    if (rdata_valid_o === 1'b1 || wr_done_o === 1'b1) begin
      if (exq.size() == 0) chk("unexpected", 9'h0, 9'h100 | {wr_done_o, rdata_o});
      else chk("result", exq.pop_front(), wr_done_o ? 9'h100 : {1'b0, rdata_o});
    end
  end
  initial begin
    seed = $urandom(89544);
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_mem();
    for (int i = 0; i < 12; i++) begin
      al[i] = (i == 0) ? '0 : (i == 1) ? '1 : {9'($urandom), 4'(i)};
      sh[i] = DATA_W'($urandom);
      do_req(1'b1, al[i], sh[i]);
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 11; i >= 0; i--) do_req(1'b0, al[i], sh[i]);
      for (int n = 0; n < 50 && exq.size() != 0; n++) @(posedge core_clk_i);
      if (p == 0) begin
        supply_ok_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        chk("fail_off", 9'h0, {7'h0, mem_ready_o, req_ready_o});
        supply_ok_i <= 1'b1;
        wait_mem();
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
